/* design/edge_sync.sv */
// two-stage synchroniser with edge detection on the external count input
`timescale 1ns/1ps
module edge_sync (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic enable_i,
   // pin and selection
   input wire logic pin_i,
   input wire logic falling_i,
   // event out
   output logic edge_o
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // only the second stage and its delayed copy feed the detector
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else if (enable_i) begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // chosen edge of the synchronised level
   assign edge_o = falling_i ? (last_reg & ~sync_reg) : (~last_reg & sync_reg);
endmodule

/* design/prescaler.sv */
// hidden 8-bit prescaler producing one tick every 2^(n+1) input events
`timescale 1ns/1ps
module prescaler (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic enable_i,
   // control
   input wire logic clear_i,
   input wire logic event_i,
   input wire logic [2:0] ratio_i,
   // tick out
   output logic tick_o
);
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic [7:0] mask;

   // terminal mask has n+1 low ones
   always_comb begin
      mask = 8'hff >> (3'h7 - ratio_i);
      count_next = count_reg + 8'h01;
   end

   // no bus path reads or loads this counter; a low byte write with the prescaler assigned (not bypassed) only clears it
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_reg <= 8'h00;
      end else if (enable_i) begin
         if (clear_i) begin
            count_reg <= 8'h00;
         end else if (event_i) begin
            count_reg <= count_next;
         end
      end
   end

   assign tick_o = event_i & ~clear_i & ((count_reg & mask) == mask);
endmodule

/* design/timer_counter.sv */
// selectable 8/16-bit timer counter with ahb-lite register slave
`timescale 1ns/1ps
module timer_counter (
   // clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // system
   input wire logic instr_cycle_i,
   input wire logic sleep_i,
   input wire logic external_count_input_i,
   // interrupt request
   output logic overflow_irq_o
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] timer_control_reg;
   logic [7:0] count_low_reg;
   logic [7:0] count_high_reg;
   logic [7:0] count_high_buffer_reg;
   logic overflow_flag_reg;
   logic overflow_irq_enable_reg;
   logic [5:0] intc_other_reg;
   logic [1:0] hold_reg;
   logic [1:0] hold_next;
   // bus address phase capture
   logic dphase_reg;
   logic dwrite_reg;
   logic [3:0] daddr_reg;
   logic [31:0] hrdata_reg;

   logic ext_edge;
   logic src_event;
   logic pre_tick;
   logic count_event;
   logic run;
   logic wr_low;
   logic rd_low;
   logic wr_ctrl;
   logic wr_high;
   logic wr_intc;
   logic addr_phase;
   logic wrap8;
   logic wrap16;
   logic overflow;
   logic [7:0] wdata;
   logic [7:0] rd_mux;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   assign addr_phase = hsel_i & hready_i & htrans_i[1];
   assign wdata = hwdata_i[7:0];
   assign wr_ctrl = dphase_reg & dwrite_reg & (daddr_reg == tmr_pkg::ADDR_CTRL);
   assign wr_low = dphase_reg & dwrite_reg & (daddr_reg == tmr_pkg::ADDR_LOW);
   assign wr_high = dphase_reg & dwrite_reg & (daddr_reg == tmr_pkg::ADDR_HIGH);
   assign wr_intc = dphase_reg & dwrite_reg & (daddr_reg == tmr_pkg::ADDR_INTC);
   // a read is acted on in its address phase so data is ready next edge
   assign rd_low = addr_phase & ~hwrite_i & (haddr_i[3:0] == tmr_pkg::ADDR_LOW)
                   & (haddr_i[31:4] == 28'h0000000);

   // capture address phase; zero-wait slave, always okay
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         dphase_reg <= 1'b0;
         dwrite_reg <= 1'b0;
         daddr_reg <= 4'h0;
      end else if (clk_en_i) begin
         dphase_reg <= addr_phase & (haddr_i[31:4] == 28'h0000000)
                       & (haddr_i[1:0] == 2'h0);
         dwrite_reg <= hwrite_i;
         daddr_reg <= haddr_i[3:0];
      end
   end

   // read mux; the live high byte has no read path
   always_comb begin
      unique case (haddr_i[3:0])
         tmr_pkg::ADDR_CTRL: rd_mux = timer_control_reg;
         tmr_pkg::ADDR_LOW: rd_mux = count_low_reg;
         tmr_pkg::ADDR_HIGH: rd_mux = count_high_buffer_reg;
         tmr_pkg::ADDR_INTC: rd_mux = {intc_other_reg[5:4], overflow_irq_enable_reg,
                                       intc_other_reg[3:2], overflow_flag_reg,
                                       intc_other_reg[1:0]};
         default: rd_mux = 8'h00;
      endcase
   end

   // read data registered from the address phase
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         hrdata_reg <= 32'h00000000;
      end else if (clk_en_i && addr_phase && !hwrite_i) begin
         hrdata_reg <= (haddr_i[31:4] == 28'h0000000) ? {24'h000000, rd_mux} : 32'h00000000;
      end
   end

   assign hrdata_o = hrdata_reg;

   // zero-wait, always-okay answer; kept in flops so every output is registered
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else if (clk_en_i) begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // count source
   // ------------------------------------------------------------
   // the pin passes two flops before the detector, so a count lands three
   // edges after the pin moves; pulses shorter than one clock period can be missed
   edge_sync u_sync (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .enable_i(clk_en_i),
      .pin_i(external_count_input_i),
      .falling_i(timer_control_reg[tmr_pkg::CTRL_EDGE]),
      .edge_o(ext_edge)
   );

   // pick pin edges or instruction cycles
   assign src_event = timer_control_reg[tmr_pkg::CTRL_SRC] ? ext_edge : instr_cycle_i;

   // prescaler sees the source events whenever running; bypass picks which feeds the count and blocks the low-write clear
   prescaler u_pre (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .enable_i(clk_en_i),
      .clear_i(wr_low & ~timer_control_reg[tmr_pkg::CTRL_BYP]),
      .event_i(src_event & run),
      .ratio_i(timer_control_reg[2:0]),
      .tick_o(pre_tick)
   );

   // run gate: enable bit and not sleeping; the write hold-off gates the count separately
   assign run = timer_control_reg[tmr_pkg::CTRL_RUN] & ~sleep_i;
   // assignment read live each cycle, so it can change on the fly
   assign count_event = run & (hold_reg == 2'h0)
                        & (timer_control_reg[tmr_pkg::CTRL_BYP] ? src_event : pre_tick);

   // wrap is judged on the value before the step, so the flag lands with the zero
   assign wrap8 = count_low_reg == 8'hff;
   assign wrap16 = wrap8 & (count_high_reg == 8'hff);
   assign overflow = count_event & ~wr_low
                     & (timer_control_reg[tmr_pkg::CTRL_W8] ? wrap8 : wrap16);

   // ------------------------------------------------------------
   // write hold-off counter
   // ------------------------------------------------------------
   // skipped cycles are lost for good; software writes an adjusted value instead
   // counts instruction cycles after a low byte write in timer mode
   always_comb begin
      hold_next = hold_reg;
      if (wr_low && !timer_control_reg[tmr_pkg::CTRL_SRC]) begin
         hold_next = tmr_pkg::WRITE_HOLD_CYCLES;
      end else if (hold_reg != 2'h0 && instr_cycle_i) begin
         hold_next = hold_reg - 2'h1;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         hold_reg <= 2'h0;
      end else if (clk_en_i) begin
         hold_reg <= hold_next;
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         timer_control_reg <= tmr_pkg::CTRL_RESET;
      end else if (clk_en_i && wr_ctrl) begin
         timer_control_reg <= wdata;
      end
   end

   // ------------------------------------------------------------
   // counter bytes
   // ------------------------------------------------------------
   // low byte: write beats increment; a wrap in the write cycle is lost since overflow is masked by wr_low
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_low_reg <= tmr_pkg::LOW_RESET;
      end else if (clk_en_i) begin
         if (wr_low) begin
            count_low_reg <= wdata;
         end else if (count_event) begin
            count_low_reg <= count_low_reg + 8'h01;
         end
      end
   end

   // high byte: loaded from buffer with the low write, frozen in 8-bit width
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_high_reg <= 8'h00;
      end else if (clk_en_i) begin
         if (wr_low && !timer_control_reg[tmr_pkg::CTRL_W8]) begin
            count_high_reg <= count_high_buffer_reg;
         end else if (count_event && wrap8 && !timer_control_reg[tmr_pkg::CTRL_W8]) begin
            count_high_reg <= count_high_reg + 8'h01;
         end
      end
   end

   // buffer: written by software, snapshots live high byte on low read in 16-bit width
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_high_buffer_reg <= tmr_pkg::HIGH_RESET;
      end else if (clk_en_i) begin
         if (wr_high) begin
            count_high_buffer_reg <= wdata;
         end else if (rd_low && !timer_control_reg[tmr_pkg::CTRL_W8]) begin
            count_high_buffer_reg <= count_high_reg;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt control
   // ------------------------------------------------------------
   // overflow set wins over a software clear in the same cycle
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         overflow_flag_reg <= 1'b0;
         overflow_irq_enable_reg <= 1'b0;
         intc_other_reg <= 6'h00;
      end else if (clk_en_i) begin
         if (overflow) begin
            overflow_flag_reg <= 1'b1;
         end else if (wr_intc) begin
            overflow_flag_reg <= wdata[tmr_pkg::INTC_IF];
         end
         if (wr_intc) begin
            overflow_irq_enable_reg <= wdata[tmr_pkg::INTC_IE];
            intc_other_reg <= {wdata[7:6], wdata[4:3], wdata[1:0]};
         end
      end
   end

   // registered request, masked by the enable bit
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         overflow_irq_o <= 1'b0;
      end else if (clk_en_i) begin
         overflow_irq_o <= overflow_flag_reg & overflow_irq_enable_reg;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   run_hold_a: assert property (clk_en_i && !timer_control_reg[tmr_pkg::CTRL_RUN] && !wr_low
                                |=> $stable(count_low_reg))
      else $error("count moved while stopped");
   sleep_hold_a: assert property (clk_en_i && sleep_i && !wr_low |=> $stable(count_low_reg))
      else $error("count moved in sleep");
   width8_high_a: assert property (clk_en_i && timer_control_reg[tmr_pkg::CTRL_W8]
                                   |=> $stable(count_high_reg))
      else $error("high byte moved in 8-bit width");
   write_hold_a: assert property (clk_en_i && wr_low && !timer_control_reg[tmr_pkg::CTRL_SRC]
                                  |=> hold_reg == 2'h2)
      else $error("hold-off not started");
   bypass_tick_a: assert property (clk_en_i && run && hold_reg == 2'h0 && !wr_low
                                   && timer_control_reg[tmr_pkg::CTRL_BYP]
                                   && !timer_control_reg[tmr_pkg::CTRL_SRC] && instr_cycle_i
                                   |=> count_low_reg == $past(count_low_reg) + 8'h01)
      else $error("timer missed a cycle");
   overflow_set_a: assert property (clk_en_i && overflow |=> overflow_flag_reg)
      else $error("overflow flag not set");
   irq_mask_a: assert property (clk_en_i && !overflow_irq_enable_reg |=> !overflow_irq_o)
      else $error("masked irq raised");
   buffer_snap_a: assert property (clk_en_i && rd_low && !wr_high
                                   && !timer_control_reg[tmr_pkg::CTRL_W8]
                                   |=> count_high_buffer_reg == $past(count_high_reg))
      else $error("buffer not loaded on low read");
   high_load_a: assert property (clk_en_i && wr_low && !timer_control_reg[tmr_pkg::CTRL_W8]
                                 |=> count_high_reg == $past(count_high_buffer_reg))
      else $error("high byte not loaded from buffer");

   // the flag only falls by a software write, never by hardware
   flag_sticky_a: assert property (clk_en_i && overflow_flag_reg && !wr_intc
                                   |=> overflow_flag_reg)
      else $error("overflow flag dropped without a write");
   // request follows flag and enable one edge later
   irq_follow_a: assert property (clk_en_i
                                  |=> overflow_irq_o == $past(overflow_flag_reg
                                                              & overflow_irq_enable_reg))
      else $error("irq does not follow flag and enable");
   // an 8-bit wrap leaves the low byte at zero
   wrap8_low_a: assert property (clk_en_i && overflow
                                 && timer_control_reg[tmr_pkg::CTRL_W8]
                                 |=> count_low_reg == 8'h00)
      else $error("8-bit wrap did not return to zero");
   // a low byte carry steps the live high byte in 16-bit width
   carry16_a: assert property (clk_en_i && count_event && wrap8 && !wr_low
                               && !timer_control_reg[tmr_pkg::CTRL_W8]
                               |=> count_high_reg == $past(count_high_reg) + 8'h01)
      else $error("high byte missed the carry");
   // no count may land while the write hold-off runs
   hold_block_a: assert property (clk_en_i && hold_reg != 2'h0 && !wr_low
                                  |=> $stable(count_low_reg))
      else $error("count moved during hold-off");
   // with the prescaler assigned only its tick may advance the count
   pre_gate_a: assert property (clk_en_i && !pre_tick && !wr_low
                                && !timer_control_reg[tmr_pkg::CTRL_BYP]
                                |=> $stable(count_low_reg))
      else $error("count moved without a prescaler tick");
   // a selected pin edge counts once when bypassed and running
   ext_count_a: assert property (clk_en_i && ext_edge && run && hold_reg == 2'h0
                                 && !wr_low && timer_control_reg[tmr_pkg::CTRL_BYP]
                                 && timer_control_reg[tmr_pkg::CTRL_SRC]
                                 |=> count_low_reg == $past(count_low_reg) + 8'h01)
      else $error("pin edge not counted");
   // a buffer write never reaches the live high byte by itself
   buffer_only_a: assert property (clk_en_i && wr_high && !count_event
                                   |=> $stable(count_high_reg))
      else $error("buffer write changed the live high byte");

   overflow_c: cover property (overflow);
   ext_edge_c: cover property (ext_edge && count_event);
   pre_tick_c: cover property (pre_tick && !timer_control_reg[tmr_pkg::CTRL_BYP]);
   low_read_c: cover property (rd_low);
   hold_c: cover property (hold_reg != 2'h0 && instr_cycle_i);
endmodule

/* design/tmr_pkg.sv */
// package with register map, field positions, reset values and timing counts for the timer
package tmr_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_LOW = 4'h4;
   localparam logic [3:0] ADDR_HIGH = 4'h8;
   localparam logic [3:0] ADDR_INTC = 4'hc;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_RUN = 7;
   localparam int CTRL_W8 = 6;
   localparam int CTRL_SRC = 5;
   localparam int CTRL_EDGE = 4;
   localparam int CTRL_BYP = 3;
   localparam int INTC_IE = 5;
   localparam int INTC_IF = 2;
   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'hff;
   localparam logic [7:0] HIGH_RESET = 8'h00;
   localparam logic [7:0] LOW_RESET = 8'h00;
   localparam logic [1:0] WRITE_HOLD_CYCLES = 2'h2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* verif/ext_count_source.sv */
// model of the external pulse source that drives the count pin
`timescale 1ns/1ps
module ext_count_source (
   // clock
   input wire logic ref_clk_i,
   // count pin
   output logic pin_o
);
   // ------------------------------------------------------------
   // pin driver
   // ------------------------------------------------------------
   // the pin idles low; each level is held four cycles so the two-flop sync sees it
   initial begin
      pin_o = 1'b0;
   end
   // invert the pin n times, one change per four clock cycles
   task automatic toggle(input int n);
      repeat (n) begin
         @(posedge ref_clk_i);
         pin_o <= ~pin_o;
         repeat (3) @(posedge ref_clk_i);
      end
   endtask
endmodule

/* verif/selectable_width_timer_counter_tb_top.sv */
// self-checking bench for the selectable width timer counter
`timescale 1ns/1ps
module selectable_width_timer_counter_tb_top;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic instr = 1'b0;
   logic sleep = 1'b0;
   logic clk_en = 1'b1;
   logic pin;
   logic irq;
   logic rd_dp = 1'b0;
   logic [31:0] exp_q[$];
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   int seed = 38893;
   logic [7:0] rv;
   logic [7:0] rh;
   // ------------------------------------------------------------
   // clock, design and partner
   // ------------------------------------------------------------
   // 250 MHz clock
   initial begin
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   timer_counter uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
      .hreadyout_o(hreadyout), .hresp_o(hresp), .instr_cycle_i(instr),
      .sleep_i(sleep), .external_count_input_i(pin), .overflow_irq_o(irq));
   ext_count_source src (.ref_clk_i(ref_clk_i), .pin_o(pin));
   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         failures++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // read data is taken at the edge that closes the data phase, oldest note first
   always @(posedge ref_clk_i) begin
      if (rd_dp) begin
         check(hrdata, exp_q.pop_front());
         check({31'h0, hresp}, 32'h0);
      end
   end
   // a hang ends the run as a mismatch
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         complete_run();
      end
   end
   // ------------------------------------------------------------
   // drivers
   // ------------------------------------------------------------
   // one ahb-lite single transfer; e is the expected byte for a read
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                       input logic [7:0] e, input logic [27:0] hi = 28'h0);
      hsel <= 1'b1;
      haddr <= {hi, a};
      hwrite <= w;
      htrans <= tmr_pkg::HTRANS_NONSEQ;
      @(posedge ref_clk_i);
      while (hreadyout !== 1'b1) @(posedge ref_clk_i);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      if (!w) begin
         exp_q.push_back({24'h0, e});
         rd_dp <= 1'b1;
      end
      @(posedge ref_clk_i);
      while (hreadyout !== 1'b1) @(posedge ref_clk_i);
      rd_dp <= 1'b0;
   endtask
   // instruction-cycle pulses, one clock wide, every fourth clock
   task automatic pulses(input int n);
      repeat (n) begin
         instr <= 1'b1;
         @(posedge ref_clk_i);
         instr <= 1'b0;
         repeat (3) @(posedge ref_clk_i);
      end
   endtask
   function automatic logic [7:0] ctl(input logic r, w, s, e, b, input logic [2:0] p);
      ctl = {5'h0, p};
      ctl[tmr_pkg::CTRL_RUN] = r;
      ctl[tmr_pkg::CTRL_W8] = w;
      ctl[tmr_pkg::CTRL_SRC] = s;
      ctl[tmr_pkg::CTRL_EDGE] = e;
      ctl[tmr_pkg::CTRL_BYP] = b;
   endfunction
   task automatic done(input string name);
      @(posedge ref_clk_i);
      $display("test %s finished", name);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      // reset values, then an unmapped place
      xfer(0, tmr_pkg::ADDR_CTRL, 8'h0, tmr_pkg::CTRL_RESET);
      xfer(0, tmr_pkg::ADDR_HIGH, 8'h0, tmr_pkg::HIGH_RESET);
      xfer(0, tmr_pkg::ADDR_INTC, 8'h0, 8'h00);
      xfer(0, tmr_pkg::ADDR_LOW, 8'h0, tmr_pkg::LOW_RESET);
      xfer(1, tmr_pkg::ADDR_CTRL, 8'h55, 8'h0, 28'h1);
      xfer(0, tmr_pkg::ADDR_CTRL, 8'h0, 8'h00, 28'h1);
      done("reset");
      // stopped 16-bit counter: buffered high byte, pulses ignored
      rv = 8'($random(seed));
      rh = 8'($random(seed));
      xfer(1, tmr_pkg::ADDR_CTRL, ctl(0, 0, 0, 0, 1, 3'h0), 8'h0);
      xfer(1, tmr_pkg::ADDR_HIGH, rh, 8'h0);
      xfer(1, tmr_pkg::ADDR_LOW, rv, 8'h0);
      xfer(1, tmr_pkg::ADDR_HIGH, ~rh, 8'h0);
      pulses(4);
      xfer(0, tmr_pkg::ADDR_LOW, 8'h0, rv);
      xfer(0, tmr_pkg::ADDR_HIGH, 8'h0, rh);
      done("buffer");
      // 8-bit timer: hold-off after a low write, wrap and masking
      xfer(1, tmr_pkg::ADDR_CTRL, ctl(1, 1, 0, 0, 1, 3'h0), 8'h0);
      xfer(1, tmr_pkg::ADDR_INTC, 8'h20, 8'h0);
      xfer(1, tmr_pkg::ADDR_LOW, 8'h10, 8'h0);
      pulses(5);
      xfer(0, tmr_pkg::ADDR_LOW, 8'h0, 8'h13);
      xfer(1, tmr_pkg::ADDR_LOW, 8'hfe, 8'h0);
      pulses(4);
      xfer(0, tmr_pkg::ADDR_INTC, 8'h0, 8'h24);
      check({31'h0, irq}, 32'h1);
      xfer(1, tmr_pkg::ADDR_INTC, 8'h04, 8'h0);
      repeat (2) @(posedge ref_clk_i);
      check({31'h0, irq}, 32'h0);
      xfer(1, tmr_pkg::ADDR_INTC, 8'h00, 8'h0);
      xfer(1, tmr_pkg::ADDR_CTRL, ctl(0, 0, 0, 0, 1, 3'h0), 8'h0);
      xfer(0, tmr_pkg::ADDR_LOW, 8'h0, 8'h00);
      xfer(0, tmr_pkg::ADDR_HIGH, 8'h0, rh);
      done("eight_bit");
      // 16-bit wrap, then sleep freezes the count
      xfer(1, tmr_pkg::ADDR_CTRL, ctl(1, 0, 0, 0, 1, 3'h0), 8'h0);
      xfer(1, tmr_pkg::ADDR_HIGH, 8'hff, 8'h0);
      xfer(1, tmr_pkg::ADDR_LOW, 8'hfe, 8'h0);
      pulses(4);
      xfer(0, tmr_pkg::ADDR_LOW, 8'h0, 8'h00);
      xfer(0, tmr_pkg::ADDR_HIGH, 8'h0, 8'h00);
      xfer(0, tmr_pkg::ADDR_INTC, 8'h0, 8'h04);
      xfer(1, tmr_pkg::ADDR_LOW, 8'h20, 8'h0);
      pulses(2);
      sleep <= 1'b1;
      pulses(5);
      sleep <= 1'b0;
      // clock enable low freezes the count as well
      clk_en <= 1'b0;
      pulses(3);
      clk_en <= 1'b1;
      xfer(0, tmr_pkg::ADDR_LOW, 8'h0, 8'h20);
      done("sixteen_bit");
      // edge selection on the pin; only the wanted edge counts
      xfer(1, tmr_pkg::ADDR_CTRL, ctl(1, 0, 1, 0, 1, 3'h0), 8'h0);
      xfer(1, tmr_pkg::ADDR_LOW, 8'h00, 8'h0);
      src.toggle(1);
      xfer(0, tmr_pkg::ADDR_LOW, 8'h0, 8'h01);
      xfer(1, tmr_pkg::ADDR_CTRL, ctl(1, 0, 1, 1, 1, 3'h0), 8'h0);
      xfer(1, tmr_pkg::ADDR_LOW, 8'h00, 8'h0);
      src.toggle(3);
      xfer(0, tmr_pkg::ADDR_LOW, 8'h0, 8'h02);
      done("edges");
      // every ratio code with the prescaler assigned on the fly
      for (int r = 0; r < 8; r++) begin
         xfer(1, tmr_pkg::ADDR_CTRL, ctl(1, 0, 1, 0, 0, r[2:0]), 8'h0);
         xfer(1, tmr_pkg::ADDR_LOW, 8'h00, 8'h0);
         src.toggle(2 * (2 * (2 << r) + 1));
         xfer(0, tmr_pkg::ADDR_LOW, 8'h0, 8'h02);
      end
      // prescaler holds one event from the last ratio; the low write must drop it
      xfer(1, tmr_pkg::ADDR_CTRL, ctl(1, 0, 1, 0, 0, 3'h0), 8'h0);
      xfer(1, tmr_pkg::ADDR_LOW, 8'h00, 8'h0);
      src.toggle(2);
      xfer(0, tmr_pkg::ADDR_LOW, 8'h0, 8'h00);
      done("prescaler");
      complete_run();
   end
endmodule
